/* File: cwo_clock_ctrl.sv */
// Clock control slice: wait mode, main clock stop detection, on-chip oscillator control.
`timescale 1ns/1ps
module cwo_clock_ctrl
	import cwo_pkg::*;
#(
	parameter int STOP_CYCLES = CWO_STOP_CYCLES,
	parameter logic [7:0] TRIM36_COARSE = 8'h5A,
	parameter logic [7:0] TRIM36_FINE = 8'h3C,
	parameter logic [7:0] TRIM32_COARSE = 8'h4B,
	parameter logic [7:0] TRIM32_FINE = 8'h2D
) (
	input wire logic clk,
	input wire logic nrst,
	input wire cwo_apb_req_t apb_req,
	output cwo_apb_rsp_t apb_rsp,
	input wire logic external_main_clock,
	input wire logic periph_irq,
	output logic stop_detect_irq,
	output cwo_clk_ctrl_t clk_ctrl
);
	initial begin
		if (STOP_CYCLES < 4 || STOP_CYCLES > 65535) begin
			$error("STOP_CYCLES out of range");
		end
	end

	typedef enum logic [1:0] {
		CWO_RUN = 2'b01,
		CWO_WAIT = 2'b10
	} cwo_state_t;

	cwo_state_t state;
	logic [7:0] stop_detect;
	logic [7:0] hs_ctrl;
	logic [7:0] divider;
	logic [7:0] coarse_trim;
	logic [7:0] fine_trim;
	logic protect;
	logic ls_stop;
	logic prescaler_init;
	logic main_stopped;
	logic main_level;
	logic main_edge;
	logic [15:0] idle_cnt;
	logic [7:0] index;
	logic wr;
	logic rd_ok;
	logic [7:0] rdata;
	logic monitor;
	logic detect_full;

	cwo_sync3 u_main_sync (
		.clk(clk),
		.nrst(nrst),
		.din(external_main_clock),
		.level(main_level),
		.edge_seen(main_edge)
	);

	assign index = apb_req.paddr[9:2];
	assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign detect_full = stop_detect[CWO_SD_EN] && stop_detect[CWO_SD_IRQ_EN];
	assign monitor = stop_detect[CWO_SD_EN] && main_stopped;

	// Main clock is considered stopped when no edge appears for STOP_CYCLES cycles.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			idle_cnt <= 16'h0000;
			main_stopped <= 1'b0;
		end else if (!stop_detect[CWO_SD_EN]) begin
			idle_cnt <= 16'h0000;
			main_stopped <= 1'b0;
		end else if (main_edge) begin
			idle_cnt <= 16'h0000;
			main_stopped <= 1'b0;
		end else if (idle_cnt >= 16'(STOP_CYCLES - 1)) begin
			main_stopped <= 1'b1;
		end else begin
			idle_cnt <= idle_cnt + 16'h0001;
		end
	end

	// Oscillation stop register with automatic fallback and guarded select bit.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			stop_detect <= CWO_RST_STOP_DETECT;
		end else begin
			if (wr && protect && index == CWO_IDX_STOP_DETECT) begin
				stop_detect[CWO_SD_EN] <= apb_req.pwdata[CWO_SD_EN];
				stop_detect[CWO_SD_IRQ_EN] <= apb_req.pwdata[CWO_SD_IRQ_EN];
				if (apb_req.pwdata[CWO_SD_SYSCLK_SEL] || !monitor) begin
					stop_detect[CWO_SD_SYSCLK_SEL] <= apb_req.pwdata[CWO_SD_SYSCLK_SEL];
				end
			end
			if (detect_full && main_stopped) begin
				stop_detect[CWO_SD_SYSCLK_SEL] <= 1'b1;
			end
		end
	end

	// Interrupt request is a level held while the stop condition stands.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			stop_detect_irq <= 1'b0;
		end else begin
			stop_detect_irq <= detect_full && main_stopped;
		end
	end

	// Write-protect and low-speed stop bits in the system control register.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			protect <= 1'b0;
			ls_stop <= 1'b0;
		end else begin
			if (wr && index == CWO_IDX_SYS_CTRL) begin
				protect <= apb_req.pwdata[CWO_SC_PROTECT];
				if (protect) begin
					ls_stop <= apb_req.pwdata[CWO_SC_LS_STOP];
				end
			end
			if (stop_detect[CWO_SD_SYSCLK_SEL]) begin
				ls_stop <= 1'b0;
			end
		end
	end

	// Wait mode: entered by writing the wait bit with protect set, left on a peripheral interrupt or the stop detection interrupt.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= CWO_RUN;
		end else begin
			case (state)
				CWO_RUN: begin
					if (wr && protect && index == CWO_IDX_SYS_CTRL &&
						apb_req.pwdata[CWO_SC_WAIT]) begin
						state <= CWO_WAIT;
					end
				end
				CWO_WAIT: begin
					if (periph_irq || stop_detect_irq) begin
						state <= CWO_RUN;
					end
				end
				default: begin
					state <= CWO_RUN;
				end
			endcase
		end
	end

	// High-speed oscillator control, divider and trim registers.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			hs_ctrl <= CWO_RST_HS_CTRL;
			divider <= CWO_RST_DIVIDER;
			coarse_trim <= CWO_RST_TRIM;
			fine_trim <= CWO_RST_TRIM;
		end else if (wr && protect) begin
			if (index == CWO_IDX_HS_CTRL) begin
				hs_ctrl <= apb_req.pwdata[7:0] & 8'h0F;
			end else if (index == CWO_IDX_DIVIDER) begin
				divider <= apb_req.pwdata[7:0] & 8'h07;
			end else if (index == CWO_IDX_COARSE_TRIM) begin
				coarse_trim <= apb_req.pwdata[7:0];
			end else if (index == CWO_IDX_FINE_TRIM) begin
				fine_trim <= apb_req.pwdata[7:0];
			end
		end
	end

	// Prescaler initialisation is a one-cycle pulse; the bit itself reads back 0.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prescaler_init <= 1'b0;
		end else begin
			prescaler_init <= wr && protect && index == CWO_IDX_PRESCALER &&
				apb_req.pwdata[CWO_PS_INIT];
		end
	end

	// Read decode.
	always_comb begin
		rdata = 8'h00;
		rd_ok = 1'b1;
		if (apb_req.paddr[11:10] != 2'b00 || apb_req.paddr[1:0] != 2'b00) begin
			rd_ok = 1'b0;
		end else if (index == CWO_IDX_STOP_DETECT) begin
			rdata = {4'h0, monitor, stop_detect[2:0]};
		end else if (index == CWO_IDX_TRIM32_FINE_F) begin
			rdata = TRIM32_FINE;
		end else if (index == CWO_IDX_HS_CTRL) begin
			rdata = hs_ctrl;
		end else if (index == CWO_IDX_COARSE_TRIM) begin
			rdata = coarse_trim;
		end else if (index == CWO_IDX_DIVIDER) begin
			rdata = divider;
		end else if (index == CWO_IDX_PRESCALER) begin
			rdata = 8'h00;
		end else if (index == CWO_IDX_TRIM36_COARSE_F) begin
			rdata = TRIM36_COARSE;
		end else if (index == CWO_IDX_TRIM36_FINE_F) begin
			rdata = TRIM36_FINE;
		end else if (index == CWO_IDX_TRIM32_COARSE_F) begin
			rdata = TRIM32_COARSE;
		end else if (index == CWO_IDX_FINE_TRIM) begin
			rdata = fine_trim;
		end else if (index == CWO_IDX_SYS_CTRL) begin
			rdata = {5'h00, ls_stop, protect, state == CWO_WAIT};
		end else if (index == CWO_IDX_STATUS) begin
			rdata = {6'h00, stop_detect_irq, state == CWO_WAIT};
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Zero-wait-state slave; unmapped addresses answer with pslverr.
	always_comb begin
		apb_rsp.pready = 1'b1;
		apb_rsp.pslverr = apb_req.psel && apb_req.penable && !rd_ok;
		apb_rsp.prdata = {24'h000000, rdata};
	end

	// Clock steering outputs, all from registers.
	always_comb begin
		clk_ctrl.cpu_clk_en = state == CWO_RUN;
		clk_ctrl.sysclk_onchip = stop_detect[CWO_SD_SYSCLK_SEL];
		clk_ctrl.ls_osc_run = !ls_stop;
		clk_ctrl.hs_osc_run = hs_ctrl[CWO_HS_EN];
		clk_ctrl.hs_source = hs_ctrl[CWO_HS_SRC_SEL];
		clk_ctrl.div128_hs = hs_ctrl[CWO_HS_DIV128_SEL];
		clk_ctrl.hs_div_code = divider[2:0];
		clk_ctrl.coarse_trim = coarse_trim;
		clk_ctrl.fine_trim = fine_trim;
		clk_ctrl.prescaler_init = prescaler_init;
	end

	logic unused_level;
	assign unused_level = main_level;
endmodule : cwo_clock_ctrl

/* File: cwo_pkg.sv */
// Package with register map, field positions and reset values of the clock control slice.
package cwo_pkg;

	// Printed offsets are not all multiples of four, so they are indexes; byte address = 4*index.
	localparam logic [7:0] CWO_IDX_STOP_DETECT = 8'h0C;
	localparam logic [7:0] CWO_IDX_TRIM32_FINE_F = 8'h15;
	localparam logic [7:0] CWO_IDX_HS_CTRL = 8'h23;
	localparam logic [7:0] CWO_IDX_COARSE_TRIM = 8'h24;
	localparam logic [7:0] CWO_IDX_DIVIDER = 8'h25;
	localparam logic [7:0] CWO_IDX_PRESCALER = 8'h28;
	localparam logic [7:0] CWO_IDX_TRIM36_COARSE_F = 8'h29;
	localparam logic [7:0] CWO_IDX_TRIM36_FINE_F = 8'h2A;
	localparam logic [7:0] CWO_IDX_TRIM32_COARSE_F = 8'h2B;
	localparam logic [7:0] CWO_IDX_FINE_TRIM = 8'h2F;
	// Registers of our own for loose control and status bits.
	localparam logic [7:0] CWO_IDX_SYS_CTRL = 8'h30;
	localparam logic [7:0] CWO_IDX_STATUS = 8'h31;

	// Field positions.
	localparam int CWO_SD_EN = 0;
	localparam int CWO_SD_IRQ_EN = 1;
	localparam int CWO_SD_SYSCLK_SEL = 2;
	localparam int CWO_SD_MONITOR = 3;
	localparam int CWO_HS_EN = 0;
	localparam int CWO_HS_SRC_SEL = 1;
	localparam int CWO_HS_DIV128_SEL = 3;
	localparam int CWO_PS_INIT = 7;
	localparam int CWO_SC_WAIT = 0;
	localparam int CWO_SC_PROTECT = 1;
	localparam int CWO_SC_LS_STOP = 2;
	localparam int CWO_ST_WAITING = 0;
	localparam int CWO_ST_IRQ = 1;

	// Reset values.
	localparam logic [7:0] CWO_RST_STOP_DETECT = 8'h04;
	localparam logic [7:0] CWO_RST_HS_CTRL = 8'h00;
	localparam logic [7:0] CWO_RST_DIVIDER = 8'h00;
	localparam logic [7:0] CWO_RST_TRIM = 8'h80;

	// Stop detector: main clock declared stopped after this many system cycles without an edge.
	localparam int CWO_STOP_TIME_NS = 2000;
	localparam int CWO_CLK_PERIOD_NS = 20;
	localparam int CWO_STOP_CYCLES = CWO_STOP_TIME_NS / CWO_CLK_PERIOD_NS;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} cwo_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} cwo_apb_rsp_t;

	typedef struct packed {
		logic cpu_clk_en;
		logic sysclk_onchip;
		logic ls_osc_run;
		logic hs_osc_run;
		logic hs_source;
		logic div128_hs;
		logic [2:0] hs_div_code;
		logic [7:0] coarse_trim;
		logic [7:0] fine_trim;
		logic prescaler_init;
	} cwo_clk_ctrl_t;

endpackage : cwo_pkg

/* File: cwo_sync3.sv */
// Three-stage input synchroniser with edge output once stages two and three agree.
`timescale 1ns/1ps
module cwo_sync3 (
	input wire logic clk,
	input wire logic nrst,
	input wire logic din,
	output logic level,
	output logic edge_seen
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level <= 1'b0;
			edge_seen <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			edge_seen <= 1'b0;
			if (s2 == s3 && s3 != level) begin
				level <= s3;
				edge_seen <= 1'b1;
			end
		end
	end
endmodule : cwo_sync3

/* File: cwo_clock_ctrl_chk.sv */
// Port checker of the clock control slice and its bind.
`timescale 1ns/1ps
module cwo_clock_ctrl_chk
	import cwo_pkg::*;
#(
	parameter int STOP_CYCLES = CWO_STOP_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire cwo_apb_req_t apb_req,
	input wire cwo_apb_rsp_t apb_rsp,
	input wire logic external_main_clock,
	input wire logic periph_irq,
	input wire logic stop_detect_irq,
	input wire cwo_clk_ctrl_t clk_ctrl
);
	logic prot;
	logic irq_ok;
	function automatic logic acc(logic w, logic [7:0] i);
		return apb_req.psel && apb_req.penable && apb_req.pwrite == w
			&& apb_req.paddr == {2'h0, i, 2'h0};
	endfunction : acc
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Shadow of the protect bit, written through the system control register.
	always_ff @(posedge clk) begin
		if (!nrst) prot <= 1'h0;
		else if (acc(1'h1, CWO_IDX_SYS_CTRL)) prot <= apb_req.pwdata[1];
	end
	// Shadow of detection and its interrupt both being enabled.
	always_ff @(posedge clk) begin
		if (!nrst) irq_ok <= 1'h0;
		else if (acc(1'h1, CWO_IDX_STOP_DETECT) && prot) irq_ok <= &apb_req.pwdata[1:0];
	end
	sequence s_pwr(logic [7:0] i);
		acc(1'h1, i) && prot;
	endsequence
	sequence s_pulse;
		clk_ctrl.prescaler_init ##1 !clk_ctrl.prescaler_init;
	endsequence
	a_div_write: assert property (s_pwr(CWO_IDX_DIVIDER) |=>
		clk_ctrl.hs_div_code == $past(apb_req.pwdata[2:0])) else $error("divider code wrong");
	a_protect_drop: assert property (acc(1'h1, CWO_IDX_DIVIDER) && !prot |=>
		$stable(clk_ctrl.hs_div_code)) else $error("locked write landed");
	a_hs_ctrl: assert property (s_pwr(CWO_IDX_HS_CTRL) |=> clk_ctrl.hs_osc_run ==
		$past(apb_req.pwdata[0]) && clk_ctrl.hs_source == $past(apb_req.pwdata[1])
		&& clk_ctrl.div128_hs == $past(apb_req.pwdata[3])) else $error("hs control wrong");
	a_presc_pulse: assert property (s_pwr(CWO_IDX_PRESCALER) ##0 apb_req.pwdata[7]
		|=> s_pulse) else $error("prescaler pulse wrong");
	a_presc_read: assert property (acc(1'h0, CWO_IDX_PRESCALER) |->
		apb_rsp.prdata == 32'h0) else $error("prescaler reads nonzero");
	a_wait_stop: assert property (s_pwr(CWO_IDX_SYS_CTRL) ##0 apb_req.pwdata[0]
		&& !periph_irq && !stop_detect_irq |=> !clk_ctrl.cpu_clk_en) else $error("cpu clock runs");
	a_wait_wake: assert property (!clk_ctrl.cpu_clk_en && periph_irq |=>
		clk_ctrl.cpu_clk_en) else $error("wait not left");
	a_ls_forced: assert property (clk_ctrl.sysclk_onchip |-> ##[0:1]
		clk_ctrl.ls_osc_run) else $error("low speed osc stopped");
	a_irq_cause: assert property (stop_detect_irq |-> $past(irq_ok))
		else $error("irq without enables");
	a_auto_select: assert property (stop_detect_irq |-> ##[0:1]
		clk_ctrl.sysclk_onchip) else $error("no fallback select");
endmodule : cwo_clock_ctrl_chk
bind cwo_clock_ctrl cwo_clock_ctrl_chk #(.STOP_CYCLES(STOP_CYCLES)) cwo_clock_ctrl_chk_inst (
	.clk(clk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.external_main_clock(external_main_clock), .periph_irq(periph_irq),
	.stop_detect_irq(stop_detect_irq), .clk_ctrl(clk_ctrl));

/* File: cwo_clock_ctrl_tb.sv */
// Self-checking bench of the clock control slice.
`timescale 1ns/1ps
module cwo_clock_ctrl_tb
	import cwo_pkg::*;
;
	localparam logic [7:0] T36C = 8'h6E;
	localparam logic [7:0] T36F = 8'h1D;
	localparam logic [7:0] T32C = 8'h57;
	localparam logic [7:0] T32F = 8'h28;
	logic clk, nrst, ext, ext_run, pirq, irq, err;
	cwo_apb_req_t req;
	cwo_apb_rsp_t rsp;
	cwo_clk_ctrl_t cc;
	logic [31:0] rd;
	logic [1:0] ext_div = 2'h0;
	int miscompares, num_checks, cyc;
	cwo_clock_ctrl #(.STOP_CYCLES(8), .TRIM36_COARSE(T36C), .TRIM36_FINE(T36F),
		.TRIM32_COARSE(T32C), .TRIM32_FINE(T32F)) cwo_clock_ctrl_inst (.clk(clk), .nrst(nrst),
		.apb_req(req), .apb_rsp(rsp), .external_main_clock(ext), .periph_irq(pirq),
		.stop_detect_irq(irq), .clk_ctrl(cc));
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	// The main clock toggles every fourth cycle so that the three-stage synchroniser follows it.
	always @(posedge clk) begin
		ext_div <= ext_div + 2'h1;
		if (ext_run && ext_div == 2'h3) ext <= ~ext;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			end_of_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge clk);
		req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: {2'h0, i, 2'h0}, pwdata: d};
		@(posedge clk);
		req.penable <= 1'h1;
		do @(posedge clk); while (rsp.pready !== 1'h1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask : xfer
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		xfer(1'h1, i, d);
		@(negedge clk);
	endtask : wr
	task automatic rchk(input string n, input logic [7:0] i, input logic [31:0] e);
		xfer(1'h0, i, 32'h0);
		chk(n, rd, e);
	endtask : rchk
	task automatic t_reset;
		rchk("stop_detect", CWO_IDX_STOP_DETECT, 32'h04);
		rchk("hs_ctrl", CWO_IDX_HS_CTRL, 32'h00);
		rchk("divider", CWO_IDX_DIVIDER, 32'h00);
		chk("outputs", {cc.cpu_clk_en, cc.sysclk_onchip, cc.ls_osc_run, cc.hs_osc_run}, 4'hE);
	endtask : t_reset
	task automatic t_div;
		wr(CWO_IDX_SYS_CTRL, 32'h00);
		wr(CWO_IDX_DIVIDER, 32'h05);
		rchk("locked divider", CWO_IDX_DIVIDER, 32'h00);
		wr(CWO_IDX_SYS_CTRL, 32'h02);
		for (int c = 0; c < 8; c++) begin
			wr(CWO_IDX_DIVIDER, {29'h1F, c[2:0]});
			chk("div code", cc.hs_div_code, c[2:0]);
		end
		rchk("divider", CWO_IDX_DIVIDER, 32'h07);
	endtask : t_div
	task automatic t_hs;
		wr(CWO_IDX_HS_CTRL, 32'h01);
		chk("hs run", cc.hs_osc_run, 1'h1);
		wr(CWO_IDX_HS_CTRL, 32'h0B); // Oscillator on and low speed running first.
		chk("hs source", {cc.hs_source, cc.div128_hs}, 2'h3);
		rchk("hs_ctrl", CWO_IDX_HS_CTRL, 32'h0B);
		wr(CWO_IDX_HS_CTRL, 32'h01); // Source goes back before the oscillator stops.
		chk("hs source", {cc.hs_source, cc.div128_hs}, 2'h0);
		wr(CWO_IDX_HS_CTRL, 32'h00);
		chk("hs run", cc.hs_osc_run, 1'h0);
	endtask : t_hs
	task automatic t_trim;
		logic [7:0] ci [2];
		logic [7:0] fi [2];
		logic [7:0] cv [2];
		logic [7:0] fv [2];
		ci = '{CWO_IDX_TRIM36_COARSE_F, CWO_IDX_TRIM32_COARSE_F};
		fi = '{CWO_IDX_TRIM36_FINE_F, CWO_IDX_TRIM32_FINE_F};
		cv = '{T36C, T32C};
		fv = '{T36F, T32F};
		for (int k = 0; k < 2; k++) begin
			wr(ci[k], {24'h0, ~cv[k]});
			rchk("factory coarse", ci[k], cv[k]);
			rchk("factory fine", fi[k], fv[k]);
			wr(CWO_IDX_COARSE_TRIM, cv[k]); // The oscillator is off here.
			wr(CWO_IDX_FINE_TRIM, fv[k]);
			chk("trims", {cc.coarse_trim, cc.fine_trim}, {cv[k], fv[k]});
		end
	endtask : t_trim
	task automatic t_presc;
		wr(CWO_IDX_PRESCALER, 32'h80);
		chk("presc pulse", cc.prescaler_init, 1'h1);
		@(negedge clk);
		chk("presc pulse", cc.prescaler_init, 1'h0);
		rchk("prescaler", CWO_IDX_PRESCALER, 32'h00);
	endtask : t_presc
	task automatic t_wait;
		wr(CWO_IDX_SYS_CTRL, 32'h03); // Interrupts are taken as masked here.
		chk("in wait", {cc.cpu_clk_en, cc.ls_osc_run}, 2'h1);
		rchk("status", CWO_IDX_STATUS, 32'h01);
		pirq <= 1'h1;
		@(posedge clk);
		@(negedge clk);
		chk("woken", cc.cpu_clk_en, 1'h1);
		@(posedge clk);
		pirq <= 1'h0;
		rchk("sys_ctrl", CWO_IDX_SYS_CTRL, 32'h02);
		wr(CWO_IDX_SYS_CTRL, 32'h03);
		chk("wait again", cc.cpu_clk_en, 1'h0);
		@(posedge clk);
		nrst <= 1'h0;
		@(posedge clk);
		nrst <= 1'h1;
		@(negedge clk);
		chk("reset wake", cc.cpu_clk_en, 1'h1);
		rchk("reset status", CWO_IDX_STATUS, 32'h00);
		wr(CWO_IDX_SYS_CTRL, 32'h02);
	endtask : t_wait
	task automatic t_stop;
		wr(CWO_IDX_STOP_DETECT, 32'h01);
		wr(CWO_IDX_SYS_CTRL, 32'h06);
		repeat (20) @(posedge clk);
		rchk("running", CWO_IDX_STOP_DETECT, 32'h01);
		chk("main clock", {cc.sysclk_onchip, cc.ls_osc_run}, 2'h0);
		ext_run <= 1'h0;
		repeat (20) @(posedge clk);
		rchk("stopped", CWO_IDX_STOP_DETECT, 32'h09);
		chk("no irq", {irq, cc.sysclk_onchip}, 2'h0);
		wr(CWO_IDX_STOP_DETECT, 32'h03);
		repeat (3) @(negedge clk);
		chk("fallback", {irq, cc.sysclk_onchip, cc.ls_osc_run}, 3'h7);
		wr(CWO_IDX_STOP_DETECT, 32'h01); // Interrupt enable off, so no automatic set.
		rchk("select kept", CWO_IDX_STOP_DETECT, 32'h0D);
		wr(CWO_IDX_STOP_DETECT, 32'h00); // Detection off before any mode change.
		rchk("disabled", CWO_IDX_STOP_DETECT, 32'h04);
		@(negedge clk);
		chk("irq off", irq, 1'h0);
		@(posedge clk);
		ext_run <= 1'h1;
		xfer(1'h0, 8'h3F, 32'h0);
		chk("unmapped", err, 1'h1);
	endtask : t_stop
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	initial begin
		req = '0;
		{nrst, ext, ext_run, pirq, cyc, miscompares, num_checks} = '0;
		ext_run = 1'h1;
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		t_reset();
		t_div();
		t_hs();
		t_trim();
		t_presc();
		t_wait();
		t_stop();
		end_of_test();
	end
endmodule : cwo_clock_ctrl_tb
